/* hw/dfc_pkg.sv */
// Shared constants for the converter front-end configuration register bank.
package dfc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets on the serial port
  // ----------------------------------------------------------------------
  localparam logic [12:0] DFC_ADDR_POINTER_OFFSET_CONFIG  = 13'h0017;
  localparam logic [12:0] DFC_ADDR_POINTER_ALIGNMENT_FLAGS = 13'h0018;
  localparam logic [12:0] DFC_ADDR_BUFFER_FILL_LEVEL      = 13'h0019;
  localparam logic [12:0] DFC_ADDR_SIGNAL_PATH_OPTIONS    = 13'h001b;
  localparam logic [12:0] DFC_ADDR_FIRST_HALFBAND_CONFIG  = 13'h001c;
  localparam logic [12:0] DFC_ADDR_SECOND_HALFBAND_CONFIG = 13'h001d;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] DFC_RST_POINTER_OFFSET   = 3'h4;
  localparam logic [7:0] DFC_RST_SIGNAL_PATH      = 8'he4;
  localparam logic [1:0] DFC_RST_FIRST_HB_MODE    = 2'h0;
  localparam logic [5:0] DFC_RST_SECOND_HB_MODE   = 6'h00;
  localparam logic [7:0] DFC_UNMAPPED_READ        = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int DFC_BIT_WARN1        = 7;
  localparam int DFC_BIT_WARN2        = 6;
  localparam int DFC_BIT_SOFT_ACK     = 2;
  localparam int DFC_BIT_SOFT_REQ     = 1;
  localparam int DFC_BIT_RESET_ALIGN  = 0;
  localparam int DFC_BIT_PREMOD_SKIP  = 7;
  localparam int DFC_BIT_INVSINC_SKIP = 6;
  localparam int DFC_BIT_NCO_SKIP     = 5;
  localparam int DFC_BIT_NCO_HALF     = 3;
  localparam int DFC_BIT_PHASE_SKIP   = 2;
  localparam int DFC_BIT_LOW_SIDEBAND = 1;
  localparam int DFC_BIT_I_TO_Q       = 0;
  localparam int DFC_BIT_STAGE_SKIP   = 0;
  localparam int DFC_HB_MODE_LSB      = 1;

  // ----------------------------------------------------------------------
  // Serial frame layout and counts
  // ----------------------------------------------------------------------
  localparam int          DFC_INSTR_BITS   = 16;
  localparam int          DFC_DATA_BITS    = 8;
  localparam int          DFC_RW_BIT       = 15;
  localparam logic [4:0]  DFC_CNT_INSTR_END = 5'd15;
  localparam logic [4:0]  DFC_CNT_FRAME_END = 5'd23;
  localparam logic [4:0]  DFC_CNT_DONE      = 5'd24;
  localparam int          DFC_PTR_BITS      = 3;
  localparam int          DFC_LEVEL_BITS    = 8;

  typedef enum logic [1:0] {
    DFC_PH_INSTR = 2'b00,
    DFC_PH_DATA  = 2'b01,
    DFC_PH_DONE  = 2'b10
  } dfc_phase_e;

endpackage : dfc_pkg

/* hw/dfc_pointer_tracker.sv */
// Input buffer pointer pair with alignment, fill level and near-collision flags.
module dfc_pointer_tracker
  import dfc_pkg::*;
(
  input  wire logic                      core_clk_in,
  input  wire logic                      reset_n_in,
  input  wire logic [2:0]                offset_in,
  input  wire logic                      soft_align_in,
  input  wire logic                      wr_adv_in,
  input  wire logic                      rd_adv_in,
  output logic      [DFC_PTR_BITS-1:0]   wr_ptr_out,
  output logic      [DFC_PTR_BITS-1:0]   rd_ptr_out,
  output logic      [DFC_LEVEL_BITS-1:0] level_out,
  output logic                           warn_out,
  output logic                           reset_aligned_out,
  output logic                           soft_ack_out
);

  logic                      hw_align_pending_reg;
  logic [DFC_PTR_BITS-1:0]   wr_ptr_next;
  logic [DFC_PTR_BITS-1:0]   rd_ptr_next;
  logic [DFC_PTR_BITS-1:0]   distance;
  logic [DFC_LEVEL_BITS-1:0] level_next;
  logic                      align_now;

  assign align_now = hw_align_pending_reg | soft_align_in;
  assign distance  = wr_ptr_out - rd_ptr_out;

  // Alignment restarts the read side at zero and puts the write side ahead by the offset.
  always_comb begin
    if (align_now) begin
      rd_ptr_next = '0;
      wr_ptr_next = offset_in;
    end else begin
      rd_ptr_next = rd_ptr_out + DFC_PTR_BITS'(rd_adv_in);
      wr_ptr_next = wr_ptr_out + DFC_PTR_BITS'(wr_adv_in);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      rd_ptr_out <= '0;
      wr_ptr_out <= DFC_RST_POINTER_OFFSET;
    end else begin
      rd_ptr_out <= rd_ptr_next;
      wr_ptr_out <= wr_ptr_next;
    end
  end

  // The hardware alignment runs once, on the first edge after reset release.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      hw_align_pending_reg <= 1'b1;
      reset_aligned_out    <= 1'b0;
    end else begin
      hw_align_pending_reg <= 1'b0;
      if (hw_align_pending_reg) begin
        reset_aligned_out <= 1'b1;
      end
    end
  end

  // The acknowledge stays set until the next reset.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      soft_ack_out <= 1'b0;
    end else if (soft_align_in) begin
      soft_ack_out <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Fill level as a thermometer code
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < DFC_LEVEL_BITS; i++) begin : g_level
    assign level_next[i] = ({1'b0, distance} > 4'(i));
  end

  // Within one position either way means distance 0, 1 or all-ones.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      level_out <= '0;
      warn_out  <= 1'b0;
    end else begin
      level_out <= level_next;
      warn_out  <= (distance <= 3'd1) || (distance == '1);
    end
  end

endmodule // dfc_pointer_tracker

/* hw/dfc_config_bank.sv */
// Serial-port register bank for the converter front-end buffer and datapath options.
//
// What this block does
// - Buffer reset puts write ahead by offset.
// - Pointers within one raise both warnings.
// - Software request bit realigns buffer pointers.
// - Acknowledge set after software-initiated alignment.
// - Reset-aligned set after hardware reset alignment.
// - Fill level reported as thermometer code.
// - Premod, inverse sinc, NCO skips reset set.
// - NCO gain bit halves modulator NCO input.
// - Bit two skips phase and offset correction.
// - Sideband bit picks high or low image.
// - Duplicate I, ignore Q, stop Q clocks.
// - First half-band mode: upper codes modulate.
// - First half-band stage skip bit.
// - Second half-band low codes stay unmodulated.
// - Second half-band upper codes modulate.
// - Second half-band stage skip bit.
module dfc_config_bank
  import dfc_pkg::*;
(
  input  wire logic                      core_clk_in,
  input  wire logic                      reset_n_in,
  input  wire logic                      spi_sclk_in,
  input  wire logic                      spi_cs_n_in,
  input  wire logic                      spi_sdi_in,
  output logic                           spi_sdo_out,
  output logic                           spi_sdo_oe_out,
  input  wire logic                      buf_wr_adv_in,
  input  wire logic                      buf_rd_adv_in,
  output logic      [DFC_PTR_BITS-1:0]   buf_wr_ptr_out,
  output logic      [DFC_PTR_BITS-1:0]   buf_rd_ptr_out,
  output logic      [DFC_LEVEL_BITS-1:0] buf_level_out,
  output logic                           premod_skip_out,
  output logic                           inv_sinc_skip_out,
  output logic                           nco_skip_out,
  output logic                           nco_half_gain_out,
  output logic                           phase_comp_skip_out,
  output logic                           low_sideband_out,
  output logic                           i_to_q_out,
  output logic                           q_clk_en_out,
  output logic      [1:0]                first_halfband_mode_out,
  output logic                           first_halfband_modulate_out,
  output logic                           first_stage_skip_out,
  output logic      [5:0]                second_halfband_mode_out,
  output logic                           second_halfband_modulate_out,
  output logic                           second_stage_skip_out
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic       sclk_s1_reg;
  logic       sclk_s2_reg;
  logic       sclk_prev_reg;
  logic       cs_n_s1_reg;
  logic       cs_n_s2_reg;
  logic       sdi_s1_reg;
  logic       sdi_s2_reg;
  logic       sclk_rise;
  logic       sclk_fall;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      sclk_s1_reg   <= 1'b0;
      sclk_s2_reg   <= 1'b0;
      sclk_prev_reg <= 1'b0;
      cs_n_s1_reg   <= 1'b1;
      cs_n_s2_reg   <= 1'b1;
      sdi_s1_reg    <= 1'b0;
      sdi_s2_reg    <= 1'b0;
    end else begin
      sclk_s1_reg   <= spi_sclk_in;
      sclk_s2_reg   <= sclk_s1_reg;
      sclk_prev_reg <= sclk_s2_reg;
      cs_n_s1_reg   <= spi_cs_n_in;
      cs_n_s2_reg   <= cs_n_s1_reg;
      sdi_s1_reg    <= spi_sdi_in;
      sdi_s2_reg    <= sdi_s1_reg;
    end
  end

  assign sclk_rise = !cs_n_s2_reg && sclk_s2_reg && !sclk_prev_reg;
  assign sclk_fall = !cs_n_s2_reg && !sclk_s2_reg && sclk_prev_reg;

  // ----------------------------------------------------------------------
  // Serial frame: 16-bit instruction, then one data byte, MSB first
  // ----------------------------------------------------------------------
  dfc_phase_e  phase_reg;
  logic [4:0]  bit_cnt_reg;
  logic [14:0] shift_reg;
  logic        is_read_reg;
  logic [12:0] addr_reg;
  logic [7:0]  rd_shift_reg;
  logic        wr_strobe_reg;
  logic [7:0]  wr_data_reg;
  logic [7:0]  read_value;
  logic [15:0] instr_word;

  assign instr_word = {shift_reg, sdi_s2_reg};

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || cs_n_s2_reg) begin
      phase_reg     <= DFC_PH_INSTR;
      bit_cnt_reg   <= '0;
      shift_reg     <= '0;
      is_read_reg   <= 1'b0;
      addr_reg      <= '0;
      wr_strobe_reg <= 1'b0;
      wr_data_reg   <= '0;
    end else begin
      wr_strobe_reg <= 1'b0;
      if (sclk_rise) begin
        shift_reg <= instr_word[14:0];
        case (phase_reg)
          DFC_PH_INSTR: begin
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
            if (bit_cnt_reg == DFC_CNT_INSTR_END) begin
              is_read_reg <= instr_word[DFC_RW_BIT];
              addr_reg    <= instr_word[12:0];
              phase_reg   <= DFC_PH_DATA;
            end
          end
          DFC_PH_DATA: begin
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
            if (bit_cnt_reg == DFC_CNT_FRAME_END) begin
              phase_reg     <= DFC_PH_DONE;
              wr_strobe_reg <= !is_read_reg;
              wr_data_reg   <= instr_word[7:0];
            end
          end
          DFC_PH_DONE: begin
            bit_cnt_reg <= DFC_CNT_DONE;
          end
          default: begin
            phase_reg <= DFC_PH_INSTR;
          end
        endcase
      end
    end
  end

  // Read data is shifted out on falling edges so the master samples it on the next rise.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || cs_n_s2_reg) begin
      rd_shift_reg   <= '0;
      spi_sdo_out    <= 1'b0;
      spi_sdo_oe_out <= 1'b0;
    end else if (phase_reg == DFC_PH_INSTR) begin
      rd_shift_reg <= read_value;
    end else if (sclk_fall && phase_reg == DFC_PH_DATA && is_read_reg) begin
      spi_sdo_out    <= rd_shift_reg[7];
      spi_sdo_oe_out <= 1'b1;
      rd_shift_reg   <= {rd_shift_reg[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------------
  logic [2:0] pointer_offset_reg;
  logic       soft_req_reg;
  logic       sel_offset;
  logic       sel_flags;
  logic       sel_path;
  logic       sel_hb1;
  logic       sel_hb2;

  assign sel_offset = wr_strobe_reg && addr_reg == DFC_ADDR_POINTER_OFFSET_CONFIG;
  assign sel_flags  = wr_strobe_reg && addr_reg == DFC_ADDR_POINTER_ALIGNMENT_FLAGS;
  assign sel_path   = wr_strobe_reg && addr_reg == DFC_ADDR_SIGNAL_PATH_OPTIONS;
  assign sel_hb1    = wr_strobe_reg && addr_reg == DFC_ADDR_FIRST_HALFBAND_CONFIG;
  assign sel_hb2    = wr_strobe_reg && addr_reg == DFC_ADDR_SECOND_HALFBAND_CONFIG;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      pointer_offset_reg <= DFC_RST_POINTER_OFFSET;
    end else if (sel_offset) begin
      pointer_offset_reg <= wr_data_reg[2:0];
    end
  end

  // The request is consumed the cycle after it is stored; a fresh write wins over the clear.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      soft_req_reg <= 1'b0;
    end else if (sel_flags && wr_data_reg[DFC_BIT_SOFT_REQ]) begin
      soft_req_reg <= 1'b1;
    end else begin
      soft_req_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      premod_skip_out     <= DFC_RST_SIGNAL_PATH[DFC_BIT_PREMOD_SKIP];
      inv_sinc_skip_out   <= DFC_RST_SIGNAL_PATH[DFC_BIT_INVSINC_SKIP];
      nco_skip_out        <= DFC_RST_SIGNAL_PATH[DFC_BIT_NCO_SKIP];
      nco_half_gain_out   <= DFC_RST_SIGNAL_PATH[DFC_BIT_NCO_HALF];
      phase_comp_skip_out <= DFC_RST_SIGNAL_PATH[DFC_BIT_PHASE_SKIP];
      low_sideband_out    <= DFC_RST_SIGNAL_PATH[DFC_BIT_LOW_SIDEBAND];
      i_to_q_out          <= DFC_RST_SIGNAL_PATH[DFC_BIT_I_TO_Q];
      q_clk_en_out        <= !DFC_RST_SIGNAL_PATH[DFC_BIT_I_TO_Q];
    end else if (sel_path) begin
      premod_skip_out     <= wr_data_reg[DFC_BIT_PREMOD_SKIP];
      inv_sinc_skip_out   <= wr_data_reg[DFC_BIT_INVSINC_SKIP];
      nco_skip_out        <= wr_data_reg[DFC_BIT_NCO_SKIP];
      nco_half_gain_out   <= wr_data_reg[DFC_BIT_NCO_HALF];
      phase_comp_skip_out <= wr_data_reg[DFC_BIT_PHASE_SKIP];
      low_sideband_out    <= wr_data_reg[DFC_BIT_LOW_SIDEBAND];
      i_to_q_out          <= wr_data_reg[DFC_BIT_I_TO_Q];
      q_clk_en_out        <= !wr_data_reg[DFC_BIT_I_TO_Q];
    end
  end

  // The modulate flags are the top mode bit: upper codes shift by the stage input rate.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      first_halfband_mode_out     <= DFC_RST_FIRST_HB_MODE;
      first_halfband_modulate_out <= DFC_RST_FIRST_HB_MODE[1];
      first_stage_skip_out        <= 1'b0;
    end else if (sel_hb1) begin
      first_halfband_mode_out     <= wr_data_reg[DFC_HB_MODE_LSB +: 2];
      first_halfband_modulate_out <= wr_data_reg[DFC_HB_MODE_LSB + 1];
      first_stage_skip_out        <= wr_data_reg[DFC_BIT_STAGE_SKIP];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      second_halfband_mode_out     <= DFC_RST_SECOND_HB_MODE;
      second_halfband_modulate_out <= DFC_RST_SECOND_HB_MODE[5];
      second_stage_skip_out        <= 1'b0;
    end else if (sel_hb2) begin
      second_halfband_mode_out     <= wr_data_reg[DFC_HB_MODE_LSB +: 6];
      second_halfband_modulate_out <= wr_data_reg[DFC_HB_MODE_LSB + 5];
      second_stage_skip_out        <= wr_data_reg[DFC_BIT_STAGE_SKIP];
    end
  end

  // ----------------------------------------------------------------------
  // Buffer pointer tracking
  // ----------------------------------------------------------------------
  logic buf_warn;
  logic reset_aligned;
  logic soft_ack;

  dfc_pointer_tracker u_tracker (
    .core_clk_in       (core_clk_in),
    .reset_n_in        (reset_n_in),
    .offset_in         (pointer_offset_reg),
    .soft_align_in     (soft_req_reg),
    .wr_adv_in         (buf_wr_adv_in),
    .rd_adv_in         (buf_rd_adv_in),
    .wr_ptr_out        (buf_wr_ptr_out),
    .rd_ptr_out        (buf_rd_ptr_out),
    .level_out         (buf_level_out),
    .warn_out          (buf_warn),
    .reset_aligned_out (reset_aligned),
    .soft_ack_out      (soft_ack)
  );

  // ----------------------------------------------------------------------
  // Readback; warning, acknowledge and reset-aligned bits come from the tracker and ignore writes
  // ----------------------------------------------------------------------
  always_comb begin
    read_value = DFC_UNMAPPED_READ;
    case (instr_word[12:0])
      DFC_ADDR_POINTER_OFFSET_CONFIG: begin
        read_value = {5'h00, pointer_offset_reg};
      end
      DFC_ADDR_POINTER_ALIGNMENT_FLAGS: begin
        read_value = DFC_UNMAPPED_READ;
        read_value[DFC_BIT_WARN1]       = buf_warn;
        read_value[DFC_BIT_WARN2]       = buf_warn;
        read_value[DFC_BIT_SOFT_ACK]    = soft_ack;
        read_value[DFC_BIT_SOFT_REQ]    = soft_req_reg;
        read_value[DFC_BIT_RESET_ALIGN] = reset_aligned;
      end
      DFC_ADDR_BUFFER_FILL_LEVEL: begin
        read_value = buf_level_out;
      end
      DFC_ADDR_SIGNAL_PATH_OPTIONS: begin
        read_value = {premod_skip_out, inv_sinc_skip_out, nco_skip_out, 1'b0,
                      nco_half_gain_out, phase_comp_skip_out, low_sideband_out, i_to_q_out};
      end
      DFC_ADDR_FIRST_HALFBAND_CONFIG: begin
        read_value = {5'h00, first_halfband_mode_out, first_stage_skip_out};
      end
      DFC_ADDR_SECOND_HALFBAND_CONFIG: begin
        read_value = {1'b0, second_halfband_mode_out, second_stage_skip_out};
      end
      default: begin
        read_value = DFC_UNMAPPED_READ;
      end
    endcase
  end

endmodule // dfc_config_bank

/* sim/dfc_config_bank_props.sv */
// Concurrent checks on the ports of the front-end configuration register bank.
module dfc_config_bank_props
  import dfc_pkg::*;
(
  input wire logic                      core_clk_in,
  input wire logic                      reset_n_in,
  input wire logic [DFC_PTR_BITS-1:0]   buf_wr_ptr_out,
  input wire logic [DFC_PTR_BITS-1:0]   buf_rd_ptr_out,
  input wire logic [DFC_LEVEL_BITS-1:0] buf_level_out,
  input wire logic                      premod_skip_out,
  input wire logic                      inv_sinc_skip_out,
  input wire logic                      nco_skip_out,
  input wire logic                      nco_half_gain_out,
  input wire logic                      phase_comp_skip_out,
  input wire logic                      low_sideband_out,
  input wire logic                      i_to_q_out,
  input wire logic                      q_clk_en_out,
  input wire logic [1:0]                first_halfband_mode_out,
  input wire logic                      first_halfband_modulate_out,
  input wire logic                      first_stage_skip_out,
  input wire logic [5:0]                second_halfband_mode_out,
  input wire logic                      second_halfband_modulate_out,
  input wire logic                      second_stage_skip_out
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking

  function automatic logic [DFC_LEVEL_BITS-1:0] fill_code(input logic [DFC_PTR_BITS-1:0] d);
    logic [DFC_LEVEL_BITS-1:0] t;
    for (int i = 0; i < DFC_LEVEL_BITS; i++) t[i] = (d > i);
    return t;
  endfunction

  // The level register lags the pointers by one cycle, so it is only judged once reset has been gone three edges.
  sequence s_release;
    !reset_n_in ##1 reset_n_in;
  endsequence

  sequence s_settled;
    reset_n_in [*3];
  endsequence

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_PTR_RESET: assert property (!reset_n_in |=> buf_rd_ptr_out == 3'h0 && buf_wr_ptr_out == 3'h4)
    else $error("pointers not at reset offset");
  AST_HW_ALIGN: assert property (s_release |=> buf_rd_ptr_out == 3'h0 && buf_wr_ptr_out == 3'h4)
    else $error("pointers not aligned after reset release");
  AST_PATH_RESET: assert property (!reset_n_in |=> premod_skip_out && inv_sinc_skip_out && nco_skip_out
    && phase_comp_skip_out && !nco_half_gain_out && !low_sideband_out && !i_to_q_out)
    else $error("datapath options not at reset values");
  AST_HB_RESET: assert property (!reset_n_in |=> first_halfband_mode_out == 2'h0 && !first_stage_skip_out
    && second_halfband_mode_out == 6'h00 && !second_stage_skip_out)
    else $error("half-band settings not at reset values");
  AST_Q_GATE: assert property (disable iff (!reset_n_in) i_to_q_out ^ q_clk_en_out)
    else $error("q clock enable does not follow duplication");
  AST_HB1_MOD: assert property (disable iff (!reset_n_in) first_halfband_modulate_out == first_halfband_mode_out[1])
    else $error("first stage modulation flag wrong");
  AST_HB2_MOD: assert property (disable iff (!reset_n_in) second_halfband_modulate_out == second_halfband_mode_out[5])
    else $error("second stage modulation flag wrong");
  AST_LEVEL: assert property (s_settled |-> buf_level_out == fill_code($past(buf_wr_ptr_out) - $past(buf_rd_ptr_out)))
    else $error("fill level not thermometer of pointer distance");
endmodule // dfc_config_bank_props

bind dfc_config_bank dfc_config_bank_props u_props (
  .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .buf_wr_ptr_out(buf_wr_ptr_out),
  .buf_rd_ptr_out(buf_rd_ptr_out), .buf_level_out(buf_level_out), .premod_skip_out(premod_skip_out),
  .inv_sinc_skip_out(inv_sinc_skip_out), .nco_skip_out(nco_skip_out), .nco_half_gain_out(nco_half_gain_out),
  .phase_comp_skip_out(phase_comp_skip_out), .low_sideband_out(low_sideband_out), .i_to_q_out(i_to_q_out),
  .q_clk_en_out(q_clk_en_out), .first_halfband_mode_out(first_halfband_mode_out),
  .first_halfband_modulate_out(first_halfband_modulate_out), .first_stage_skip_out(first_stage_skip_out),
  .second_halfband_mode_out(second_halfband_mode_out), .second_halfband_modulate_out(second_halfband_modulate_out),
  .second_stage_skip_out(second_stage_skip_out));

/* sim/dfc_config_bank_tb.sv */
// Self-checking bench for the front-end configuration register bank.
module dfc_config_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------------
  localparam int HALF           = 6;
  localparam int TIMEOUT_CYCLES = 30000;
  localparam int N_ROWS         = 18;
  localparam logic [12:0] RA [6] = '{13'h0017, 13'h0018, 13'h0019, 13'h001b, 13'h001c, 13'h001d};
  localparam logic [7:0]  RV [6] = '{8'h04, 8'h01, 8'h0f, 8'he4, 8'h00, 8'h00};
  // Each row: address, data written, data expected on read back.
  localparam logic [28:0] ROWS [N_ROWS] = '{
    {13'h001b, 8'hff, 8'hef}, {13'h001b, 8'h00, 8'h00}, {13'h001b, 8'h0b, 8'h0b}, {13'h001c, 8'h01, 8'h01},
    {13'h001c, 8'h02, 8'h02}, {13'h001c, 8'h04, 8'h04}, {13'h001c, 8'hff, 8'h07}, {13'h001d, 8'h12, 8'h12},
    {13'h001d, 8'h24, 8'h24}, {13'h001d, 8'h37, 8'h37}, {13'h001d, 8'h48, 8'h48}, {13'h001d, 8'h5b, 8'h5b},
    {13'h001d, 8'h6c, 8'h6c}, {13'h001d, 8'hff, 8'h7f}, {13'h0017, 8'hff, 8'h07}, {13'h0017, 8'h02, 8'h02},
    {13'h001a, 8'hff, 8'h00}, {13'h0019, 8'hff, 8'h0f}};

  logic        core_clk_in = 1'b0;
  logic        reset_n_in, spi_sclk_in, spi_cs_n_in, spi_sdi_in, buf_wr_adv_in, buf_rd_adv_in;
  logic        spi_sdo_out, oe;
  logic [2:0]  wr_ptr, rd_ptr;
  logic [7:0]  level, rdv, p, h1, h2;
  wire  [19:0] outs;
  int          failures, comparisons, cycle_count;

  always #5 core_clk_in = ~core_clk_in;

  dfc_config_bank dut (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .spi_sclk_in(spi_sclk_in), .spi_cs_n_in(spi_cs_n_in),
    .spi_sdi_in(spi_sdi_in), .spi_sdo_out(spi_sdo_out), .spi_sdo_oe_out(oe), .buf_wr_adv_in(buf_wr_adv_in),
    .buf_rd_adv_in(buf_rd_adv_in), .buf_wr_ptr_out(wr_ptr), .buf_rd_ptr_out(rd_ptr), .buf_level_out(level),
    .premod_skip_out(outs[19]), .inv_sinc_skip_out(outs[18]), .nco_skip_out(outs[17]),
    .nco_half_gain_out(outs[16]), .phase_comp_skip_out(outs[15]), .low_sideband_out(outs[14]),
    .i_to_q_out(outs[13]), .q_clk_en_out(outs[12]), .first_halfband_mode_out(outs[11:10]),
    .first_halfband_modulate_out(outs[9]), .first_stage_skip_out(outs[8]), .second_halfband_mode_out(outs[7:2]),
    .second_halfband_modulate_out(outs[1]), .second_stage_skip_out(outs[0]));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  function automatic logic [19:0] exp_outs(input logic [7:0] pv, input logic [7:0] f1, input logic [7:0] f2);
    return {pv[7], pv[6], pv[5], pv[3], pv[2], pv[1], pv[0], ~pv[0], f1[2:1], f1[2], f1[0], f2[6:1], f2[6], f2[0]};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test;
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One whole frame; sdo is sampled late in each of the 8 data-byte low phases, well after the synchronised update.
  task automatic spi(input logic rd, input logic [12:0] addr, input logic [7:0] wd, output logic [7:0] rdat);
    logic [23:0] word;
    word = {rd, 2'b00, addr, wd};
    rdat = 8'h00;
    spi_cs_n_in <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      spi_sdi_in  <= word[23-i];
      spi_sclk_in <= 1'b0;
      repeat (HALF) @(posedge core_clk_in);
      if (i >= 16) rdat[23-i] = spi_sdo_out;
      if (i == 23) check("sdo enable", oe, rd);
      spi_sclk_in <= 1'b1;
      repeat (HALF) @(posedge core_clk_in);
    end
    spi_sclk_in <= 1'b0;
    repeat (HALF) @(posedge core_clk_in);
    spi_cs_n_in <= 1'b1;
    repeat (8) @(posedge core_clk_in);
  endtask

  task automatic pulse(input logic w, input logic r, input int n);
    repeat (n) begin
      buf_wr_adv_in <= w;
      buf_rd_adv_in <= r;
      @(posedge core_clk_in);
    end
    buf_wr_adv_in <= 1'b0;
    buf_rd_adv_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
  endtask

  task automatic do_reset;
    reset_n_in <= 1'b0;
    repeat (12) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
  endtask

  always @(posedge core_clk_in) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == TIMEOUT_CYCLES) begin
      failures++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset_n_in    = 1'b0;
    spi_sclk_in   = 1'b0;
    spi_cs_n_in   = 1'b1;
    spi_sdi_in    = 1'b0;
    buf_wr_adv_in = 1'b0;
    buf_rd_adv_in = 1'b0;
    cycle_count   = 0;
    @(posedge core_clk_in);
    do_reset();
    check("reset outputs", outs, exp_outs(8'he4, 8'h00, 8'h00));
    check("reset level", level, 8'h0f);
    check("reset write pointer", wr_ptr, 3'h4);
    for (int k = 0; k < 6; k++) begin
      spi(1'b1, RA[k], 8'h00, rdv);
      check("reset read", rdv, RV[k]);
    end
    p  = 8'he4;
    h1 = 8'h00;
    h2 = 8'h00;
    for (int k = 0; k < N_ROWS; k++) begin
      spi(1'b0, ROWS[k][28:16], ROWS[k][15:8], rdv);
      spi(1'b1, ROWS[k][28:16], 8'h00, rdv);
      check("read back", rdv, ROWS[k][7:0]);
      if (ROWS[k][28:16] == 13'h001b) p = ROWS[k][7:0];
      if (ROWS[k][28:16] == 13'h001c) h1 = ROWS[k][7:0];
      if (ROWS[k][28:16] == 13'h001d) h2 = ROWS[k][7:0];
      check("outputs", outs, exp_outs(p, h1, h2));
    end
    pulse(1'b1, 1'b0, 3);
    check("level distance 7", level, 8'h7f);
    spi(1'b1, 13'h0018, 8'h00, rdv);
    check("flags distance 7", rdv, 8'hc1);
    pulse(1'b0, 1'b1, 4);
    spi(1'b1, 13'h0018, 8'h00, rdv);
    check("flags distance 3", rdv, 8'h01);
    spi(1'b0, 13'h0018, 8'hfe, rdv);
    check("aligned read pointer", rd_ptr, 3'h0);
    check("aligned write pointer", wr_ptr, 3'h2);
    check("aligned level", level, 8'h03);
    spi(1'b1, 13'h0018, 8'h00, rdv);
    check("flags after align", rdv, 8'h05);
    pulse(1'b0, 1'b1, 1);
    spi(1'b1, 13'h0018, 8'h00, rdv);
    check("flags distance 1", rdv, 8'hc5);
    do_reset();
    check("second reset outputs", outs, exp_outs(8'he4, 8'h00, 8'h00));
    spi(1'b1, 13'h0018, 8'h00, rdv);
    check("flags after second reset", rdv, 8'h01);
    spi(1'b1, 13'h0017, 8'h00, rdv);
    check("offset after second reset", rdv, 8'h04);
    end_of_test();
  end
endmodule // dfc_config_bank_tb
